/* hdl/ccp_block.sv */
/*
 * Top of the five-channel capture/PWM block: APB register file, pin
 * synchronisers, the shared 16-bit time base and the five channels.
 * Assumes an APB master on i_sys_clk; pins and the external reset input are
 * asynchronous and are synchronised here before any logic reads them.
 */
`timescale 1ns/1ps
`default_nettype none
module ccp_block
    import ccp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [N_CH-1:0] i_pin_in,
    output logic [N_CH-1:0] o_pin_out,
    output logic [N_CH-1:0] o_pin_oe_n,
    input wire logic i_ext_reset
);
    typedef struct packed {
        logic ers_s1;
        logic ers_s2;
        logic [N_CH-1:0] pin_s1;
        logic [N_CH-1:0] pin_s2;
        logic [N_CH-1:0][15:0] value;
        logic [N_CH-1:0][7:0] ctl;
        logic [N_CH-1:0][2:0] src;
        logic tmr_on;
        logic [4:0] tmr_mode;
        logic [15:0] period;
        logic [N_CH-1:0] flags;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } top_reg_t;

    top_reg_t st_ff;
    top_reg_t nxt_st;
    timebase_if tb ();
    logic [N_CH-1:0] cap_pulse;
    logic [N_CH-1:0] ch_level;
    logic [N_CH-1:0] sel_src;
    logic [IDX_W-1:0] idx;
    logic setup_ph;
    logic wr_take;

    // The two low address bits must be zero; the index is the word number.
    assign idx = i_paddr[ADDR_W-1:2];
    assign setup_ph = i_psel & ~i_penable;
    // A write lands only on the edge where the master sees pready high.
    assign wr_take = i_psel & i_penable & st_ff.pready & i_pwrite & ~st_ff.pslverr;

    // Shared time base; the external reset input reaches it only after two flops.
    ccp_timebase u_timebase (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_on(st_ff.tmr_on),
        .i_mode(st_ff.tmr_mode),
        .i_period(st_ff.period),
        .i_ers(st_ff.ers_s2),
        .tb(tb.src)
    );

    // One channel per slot; each picks its capture source among the synced pins.
    generate
        for (genvar k = 0; k < N_CH; k++) begin : g_ch
            assign sel_src[k] = (int'(st_ff.src[k]) < N_CH) ? st_ff.pin_s2[st_ff.src[k]] : 1'b0;
            ccp_channel u_channel (
                .i_sys_clk(i_sys_clk),
                .i_rst_n(i_rst_n),
                .tb(tb.snk),
                .i_en(st_ff.ctl[k][CTL_EN_BIT]),
                .i_mode(st_ff.ctl[k][3:0]),
                .i_od(st_ff.ctl[k][CTL_OD_BIT]),
                .i_src(sel_src[k]),
                .i_duty(st_ff.value[k]),
                .o_capture(cap_pulse[k]),
                .o_level(ch_level[k]),
                .o_pin_out(o_pin_out[k]),
                .o_pin_oe_n(o_pin_oe_n[k])
            );
        end
    endgenerate

    // Register file, synchronisers and capture updates in one next-state process.
    always_comb begin
        nxt_st = st_ff;
        // Pins and the external reset pass two flops before anything reads them.
        nxt_st.ers_s1 = i_ext_reset;
        nxt_st.ers_s2 = st_ff.ers_s1;
        nxt_st.pin_s1 = i_pin_in;
        nxt_st.pin_s2 = st_ff.pin_s1;

        // Read data and the answer are prepared in the setup cycle, so every
        // access completes with zero wait states.
        nxt_st.pready = setup_ph;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata = 32'h0000_0000;
        if (setup_ph) begin
            if (i_paddr[1:0] != 2'h0) begin
                nxt_st.pslverr = 1'b1;
            end else if (idx == IDX_TMR_CTL) begin
                nxt_st.prdata[TMR_ON_BIT] = st_ff.tmr_on;
                nxt_st.prdata[4:0] = st_ff.tmr_mode;
            end else if (idx == IDX_TMR_PERIOD) begin
                nxt_st.prdata[15:0] = st_ff.period;
            end else if (idx == IDX_FLAGS) begin
                nxt_st.prdata[N_CH-1:0] = st_ff.flags;
            end else if (idx == IDX_TMR_COUNT) begin
                nxt_st.prdata[15:0] = tb.count;
            end else begin
                nxt_st.pslverr = 1'b1;
                for (int k = 0; k < N_CH; k++) begin
                    // Each byte is read on its own; no shadow copy ties the pair.
                    if (idx == IDX_VALUE[k]) begin
                        nxt_st.prdata[7:0] = st_ff.value[k][7:0];
                        nxt_st.pslverr = 1'b0;
                    end else if (idx == IDX_VALUE[k] + IDX_HIGH_STEP) begin
                        nxt_st.prdata[7:0] = st_ff.value[k][15:8];
                        nxt_st.pslverr = 1'b0;
                    end else if (idx == IDX_CONTROL[k]) begin
                        nxt_st.prdata[7:0] = st_ff.ctl[k];
                        nxt_st.prdata[CTL_OUT_BIT] = ch_level[k];
                        nxt_st.pslverr = 1'b0;
                    end else if (idx == IDX_SOURCE[k]) begin
                        nxt_st.prdata[2:0] = st_ff.src[k];
                        nxt_st.pslverr = 1'b0;
                    end
                end
            end
        end

        // Register writes.
        if (wr_take) begin
            if (idx == IDX_TMR_CTL) begin
                nxt_st.tmr_on = i_pwdata[TMR_ON_BIT];
                nxt_st.tmr_mode = i_pwdata[4:0];
            end else if (idx == IDX_TMR_PERIOD) begin
                nxt_st.period = i_pwdata[15:0];
            end else if (idx == IDX_FLAGS) begin
                // Writing a one clears that flag; zeros leave flags alone.
                nxt_st.flags = st_ff.flags & ~i_pwdata[N_CH-1:0];
            end else begin
                for (int k = 0; k < N_CH; k++) begin
                    if (idx == IDX_VALUE[k]) begin
                        nxt_st.value[k][7:0] = i_pwdata[7:0];
                    end else if (idx == IDX_VALUE[k] + IDX_HIGH_STEP) begin
                        nxt_st.value[k][15:8] = i_pwdata[7:0];
                    end else if (idx == IDX_CONTROL[k]) begin
                        // The output level bit is read-only and never stored.
                        nxt_st.ctl[k] = i_pwdata[7:0] & CTL_WR_MASK;
                    end else if (idx == IDX_SOURCE[k]) begin
                        nxt_st.src[k] = i_pwdata[2:0];
                    end
                end
            end
        end

        // Captures come last so that they beat a software write in the same
        // cycle: the new count always lands and the flag is never lost.
        for (int k = 0; k < N_CH; k++) begin
            if (cap_pulse[k]) begin
                nxt_st.value[k] = tb.count;
                nxt_st.flags[k] = 1'b1;
            end
        end
    end

    // Synchronous reset; the period comes up at its full range.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
            st_ff.period <= PERIOD_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Bus answers come straight from their flops.
    assign o_prdata = st_ff.prdata;
    assign o_pready = st_ff.pready;
    assign o_pslverr = st_ff.pslverr;
endmodule
`default_nettype wire

/* hdl/ccp_channel.sv */
/*
 * One capture/PWM channel: edge qualifier with prescaler and PWM output stage.
 * Assumes a synchronised capture source and the shared time base.
 */
`timescale 1ns/1ps
`default_nettype none
module ccp_channel
    import ccp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    timebase_if.snk tb,
    input wire logic i_en,
    input wire logic [3:0] i_mode,
    input wire logic i_od,
    input wire logic i_src,
    input wire logic [15:0] i_duty,
    output logic o_capture,
    output logic o_level,
    output logic o_pin_out,
    output logic o_pin_oe_n
);
    typedef struct packed {
        logic src_q;
        logic [3:0] presc;
        logic capture;
        logic level;
        logic pin_out;
        logic pin_oe_n;
    } ch_reg_t;
    ch_reg_t st_ff;
    ch_reg_t nxt_st;
    logic rise;
    logic fall;

    assign rise = i_src & ~st_ff.src_q;
    assign fall = ~i_src & st_ff.src_q;

    // Event qualifier and PWM level; the prescaler restarts in every mode but the two prescaled rise modes.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.src_q = i_src;
        nxt_st.capture = 1'b0;
        nxt_st.level = 1'b0;
        nxt_st.presc = 4'h0;
        if (i_en) begin
            case (ccp_mode_t'(i_mode))
                MODE_CAP_FALL: nxt_st.capture = fall;
                MODE_CAP_RISE: nxt_st.capture = rise;
                MODE_CAP_RISE4: begin
                    nxt_st.presc = st_ff.presc + {3'h0, rise};
                    nxt_st.capture = rise & (st_ff.presc[1:0] == PRESC_4TH[1:0]);
                end
                MODE_CAP_RISE16: begin
                    nxt_st.presc = st_ff.presc + {3'h0, rise};
                    nxt_st.capture = rise & (st_ff.presc == PRESC_16TH);
                end
                MODE_CAP_BOTH: nxt_st.capture = rise | fall;
                MODE_PWM: begin
                    // A held timer never matches, so the level rides through the hold.
                    nxt_st.level = st_ff.level;
                    if (tb.restart) begin
                        nxt_st.level = 1'b1;
                    end else if (tb.running && (tb.count == i_duty)) begin
                        nxt_st.level = 1'b0;
                    end
                end
                default: nxt_st.capture = 1'b0;
            endcase
        end
        // Open-drain only ever pulls low and releases for a high level.
        nxt_st.pin_out = 1'b0;
        nxt_st.pin_oe_n = 1'b1;
        if (i_en && (ccp_mode_t'(i_mode) == MODE_PWM)) begin
            nxt_st.pin_out = i_od ? 1'b0 : nxt_st.level;
            nxt_st.pin_oe_n = i_od ? nxt_st.level : 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
            st_ff.pin_oe_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_capture = st_ff.capture;
    assign o_level = st_ff.level;
    assign o_pin_out = st_ff.pin_out;
    assign o_pin_oe_n = st_ff.pin_oe_n;
endmodule
`default_nettype wire

/* hdl/ccp_timebase.sv */
/*
 * 16-bit time base with period reset and level-triggered hardware limit.
 * Assumes the external reset input arrives already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
module ccp_timebase
    import ccp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_on,
    input wire logic [4:0] i_mode,
    input wire logic [15:0] i_period,
    input wire logic i_ers,
    timebase_if.src tb
);
    typedef struct packed {
        tb_state_t state;
        logic [1:0] dly;
        logic [15:0] count;
        logic restart;
        logic on_q;
    } tb_reg_t;
    tb_reg_t st_ff;
    tb_reg_t nxt_st;
    logic hold_req;

    // Hold request honours the external input only while the timer is on.
    assign hold_req = i_on & (((i_mode == TMR_HOLD_LOW) & ~i_ers)
                              | ((i_mode == TMR_HOLD_HIGH) & i_ers));

    // The count is 16 bits wide; no 8-bit base is offered.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.restart = 1'b0;
        nxt_st.on_q = i_on;
        if (!i_on) begin
            nxt_st.state = TB_RUN;
            nxt_st.dly = 2'h0;
        end else begin
            if (!st_ff.on_q) begin
                nxt_st.restart = 1'b1;
            end
            case (st_ff.state)
                TB_RUN, TB_ARMING: begin
                    if (st_ff.count == i_period) begin
                        nxt_st.count = 16'h0000;
                        nxt_st.restart = 1'b1;
                    end else begin
                        nxt_st.count = st_ff.count + 16'h0001;
                    end
                    if (!hold_req) begin
                        nxt_st.state = TB_RUN;
                    end else if (st_ff.state == TB_RUN) begin
                        nxt_st.state = TB_ARMING;
                        nxt_st.dly = 2'h1;
                    end else if (st_ff.dly == ERS_DELAY_CLKS - 2'h1) begin
                        nxt_st.state = TB_HELD;
                        nxt_st.count = 16'h0000;
                        nxt_st.restart = 1'b0;
                    end
                end
                TB_HELD: begin
                    if (!hold_req) begin
                        nxt_st.state = TB_RELEASING;
                        nxt_st.dly = 2'h1;
                    end
                end
                default: begin
                    if (hold_req) begin
                        nxt_st.state = TB_HELD;
                    end else if (st_ff.dly == ERS_DELAY_CLKS - 2'h1) begin
                        nxt_st.state = TB_RUN;
                        nxt_st.restart = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tb.count = st_ff.count;
    assign tb.restart = st_ff.restart;
    assign tb.running = st_ff.on_q & ((st_ff.state == TB_RUN) | (st_ff.state == TB_ARMING));
endmodule
`default_nettype wire

/* include/ccp_pkg.sv */
/*
 * Shared constants for the five-channel capture and PWM block: register
 * indices, field positions, reset values, mode encodings and timing counts.
 * Assumes a 32-bit APB slave where the byte address is four times the index.
 */
// How it works
// - Capture copies 16-bit timer count into value.
// - Event: fall, rise, 4th, 16th rise, both.
// - Capture sets sticky flag; only software clears.
// - New capture overwrites unread value, no overrun.
// - Value bytes are read separately, never latched.
// - Time base is a 16-bit timer only.
// - PWM output optionally open-drain instead of push-pull.
// - Timer mode 00110 holds counter while input low.
// - Timer mode 00111 holds counter while input high.
// - Timer off ignores external reset input entirely.
// - PWM high at start, low at duty match.
// - Timer resets on period match or two clocks asserted.
// - Restart next clock after match, two after release.
// - Output stays high through reset until duty match.
package ccp_pkg;
    localparam int N_CH = 5;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    // Printed register indices per channel, channel 1 in the lowest slot.
    localparam logic [N_CH-1:0][IDX_W-1:0] IDX_VALUE = {10'h31c, 10'h318, 10'h314, 10'h310, 10'h30c};
    localparam logic [N_CH-1:0][IDX_W-1:0] IDX_CONTROL = {10'h31e, 10'h31a, 10'h316, 10'h312, 10'h30e};
    localparam logic [N_CH-1:0][IDX_W-1:0] IDX_SOURCE = {10'h31f, 10'h31b, 10'h317, 10'h313, 10'h30f};
    localparam logic [IDX_W-1:0] IDX_HIGH_STEP = 10'h001;
    localparam logic [IDX_W-1:0] IDX_TMR_CTL = 10'h320;
    localparam logic [IDX_W-1:0] IDX_TMR_PERIOD = 10'h321;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h322;
    localparam logic [IDX_W-1:0] IDX_TMR_COUNT = 10'h323;
    // Channel control fields.
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_OD_BIT = 6;
    localparam int CTL_OUT_BIT = 5;
    localparam int CTL_FMT_BIT = 4;
    localparam logic [7:0] CTL_WR_MASK = 8'hdf;
    // Timer control fields, period reset value, hold delay and capture prescaler counts.
    localparam int TMR_ON_BIT = 7;
    localparam logic [4:0] TMR_HOLD_LOW = 5'h06;
    localparam logic [4:0] TMR_HOLD_HIGH = 5'h07;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [1:0] ERS_DELAY_CLKS = 2'h2;
    localparam logic [3:0] PRESC_4TH = 4'h3;
    localparam logic [3:0] PRESC_16TH = 4'hf;
    typedef enum logic [3:0] {
        MODE_OFF = 4'b0000,
        MODE_CAP_FALL = 4'b0001,
        MODE_CAP_RISE = 4'b0010,
        MODE_CAP_RISE4 = 4'b0011,
        MODE_CAP_RISE16 = 4'b0100,
        MODE_CAP_BOTH = 4'b0101,
        MODE_PWM = 4'b0110
    } ccp_mode_t;
    typedef enum logic [1:0] {
        TB_RUN = 2'b00,
        TB_ARMING = 2'b01,
        TB_HELD = 2'b10,
        TB_RELEASING = 2'b11
    } tb_state_t;
endpackage

/* include/timebase_if.sv */
/*
 * Carries the shared timer count and its start marks to every channel.
 * Assumes one driver, the time base, on the same clock as the channels.
 */
`timescale 1ns/1ps
`default_nettype none
interface timebase_if;
    logic [15:0] count;
    logic restart;
    logic running;
    modport src (output count, output restart, output running);
    modport snk (input count, input restart, input running);
endinterface
`default_nettype wire

/* verification/ccp_block_assertions.sv */
/*
 * Checker for the capture/PWM top: APB answer timing and pin drive rules.
 * Assumes it is bound to ccp_block and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module ccp_block_checker
    import ccp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [N_CH-1:0] o_pin_out,
    input wire logic [N_CH-1:0] o_pin_oe_n,
    input wire logic i_ext_reset
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] tmr_ctl_ff;
    logic [7:0] ctl1_ff;
    logic wr_done;
    assign wr_done = i_psel && i_penable && o_pready && i_pwrite;
    // Shadows of the mode registers, because the pin rules depend on the mode in force.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            tmr_ctl_ff <= 8'h00;
            ctl1_ff <= 8'h00;
        end else begin
            if (wr_done && i_paddr == {IDX_TMR_CTL, 2'b00}) tmr_ctl_ff <= i_pwdata[7:0];
            if (wr_done && i_paddr == {IDX_CONTROL[0], 2'b00}) ctl1_ff <= i_pwdata[7:0];
        end
    end
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_held_high;
        (i_ext_reset && tmr_ctl_ff == {3'b100, TMR_HOLD_HIGH})[*8];
    endsequence
    a_answer_next: assert property (s_setup |=> o_pready) else $error("no answer after setup");
    a_answer_pulse: assert property (o_pready |=> !o_pready) else $error("ready held too long");
    a_answer_cause: assert property (o_pready |-> $past(i_psel) && !$past(i_penable)) else $error("ready unasked");
    a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    a_misalign_err: assert property (s_setup ##0 (i_paddr[1:0] != 2'b00) |=> o_pslverr) else $error("no error");
    a_err_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0) else $error("refused read data");
    a_upper_zero: assert property (o_pready && !i_pwrite |-> o_prdata[31:16] == 16'h0) else $error("upper bits set");
    a_push_pull: assert property ((ctl1_ff[7:6] == 2'b10 && ctl1_ff[3:0] == MODE_PWM)[*3] |-> !o_pin_oe_n[0])
        else $error("push-pull pin released");
    a_drain_low: assert property ((ctl1_ff[7:6] == 2'b11 && ctl1_ff[3:0] == MODE_PWM)[*3] |-> !o_pin_out[0])
        else $error("open-drain pin driven high");
    a_hold_keeps: assert property (s_held_high ##0 o_pin_out[0] |=> o_pin_out[0])
        else $error("output fell during hold");
endmodule
`default_nettype wire

/* verification/ccp_pin_model.sv */
/*
 * Far side of the channel pins: a signal source on each pin and a pull-up.
 * Assumes the block releases a pin by raising its active-low enable.
 */
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_model
    import ccp_pkg::*;
(
    input wire logic [N_CH-1:0] i_drive,
    input wire logic [N_CH-1:0] i_drive_en,
    input wire logic [N_CH-1:0] i_pin_out,
    input wire logic [N_CH-1:0] i_pin_oe_n,
    output logic [N_CH-1:0] o_wire
);
    // A released, undriven pin floats up to the pull-up level, never to its last value.
    always_comb begin
        for (int k = 0; k < N_CH; k++) begin
            if (!i_pin_oe_n[k]) o_wire[k] = i_pin_out[k];
            else if (i_drive_en[k]) o_wire[k] = i_drive[k];
            else o_wire[k] = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* verification/tb_ccp_capture_pwm_hwlimit.sv */
/*
 * Self-checking bench for the capture/PWM block: registers, capture modes,
 * hardware-limit timer and pin drive. Assumes the APB timing of the block.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module tb_ccp_capture_pwm_hwlimit;
    import ccp_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ext_reset, rerr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [N_CH-1:0] drive, drive_en, wire_lvl, pin_out, pin_oe_n;
    int fails = 0;
    int n_tests = 0;
    ccp_block dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_pin_in(wire_lvl), .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n), .i_ext_reset(ext_reset));
    ccp_pin_model far (.i_drive(drive), .i_drive_en(drive_en), .i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n),
        .o_wire(wire_lvl));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // One transfer; an edge passes first so the strobe never moves twice in one step.
    task automatic apb(input logic [ADDR_W-1:0] a, input logic wr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHECK(pready, 1'b1)
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        apb({idx, 2'b00}, 1'b1, d);
    endtask
    task automatic rreg(input logic [IDX_W-1:0] idx);
        apb({idx, 2'b00}, 1'b0, 32'h0);
    endtask
    task automatic wait_pin(input logic lvl, output int n);
        n = 0;
        while (pin_out[0] !== lvl && n < 200) begin
            @(posedge clk);
            n++;
        end
        `CHECK(pin_out[0], lvl)
    endtask
    task automatic test_regs();
        rreg(IDX_TMR_PERIOD);
        `CHECK(rdata[15:0], PERIOD_RESET)
        apb(12'h001, 1'b0, 32'h0);
        `CHECK(rerr, 1'b1)
        apb(12'h000, 1'b1, 32'h5);
        `CHECK(rerr, 1'b1)
        wreg(IDX_CONTROL[0], 32'hff);
        rreg(IDX_CONTROL[0]);
        `CHECK(rdata[7:4], 4'hd)
        wreg(IDX_CONTROL[0], 32'h0);
        wreg(IDX_TMR_COUNT, 32'h1234);
        rreg(IDX_TMR_COUNT);
        `CHECK(rdata, 32'h0)
        $display("test_regs done");
    endtask
    // Every event mode; the flag must appear exactly at the qualifying edge and then stay.
    task automatic test_modes();
        ccp_mode_t modes[5] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_BOTH, MODE_CAP_RISE4, MODE_CAP_RISE16};
        int r;
        int f;
        logic exp;
        for (int i = 0; i < 5; i++) begin
            wreg(IDX_CONTROL[0], 32'h0);
            wreg(IDX_FLAGS, 32'h1f);
            wreg(IDX_CONTROL[0], {24'h0, 4'h8, modes[i]});
            r = 0;
            f = 0;
            for (int e = 0; e < 32; e++) begin
                drive[0] <= ~drive[0];
                if (e % 2 == 1) f++;
                else r++;
                repeat (8) @(posedge clk);
                rreg(IDX_FLAGS);
                case (modes[i])
                    MODE_CAP_FALL: exp = (f >= 1);
                    MODE_CAP_RISE: exp = (r >= 1);
                    MODE_CAP_RISE4: exp = (r >= 4);
                    MODE_CAP_RISE16: exp = (r >= 16);
                    default: exp = (r + f >= 1);
                endcase
                `CHECK(rdata[0], exp)
            end
        end
        $display("test_modes done");
    endtask
    // Timer frozen between captures so the stored count is known exactly.
    task automatic test_capture();
        logic [15:0] c;
        for (int k = 0; k < 2; k++) begin
            wreg(IDX_TMR_CTL, 32'h80);
            repeat (37 + k * 20) @(posedge clk);
            wreg(IDX_TMR_CTL, 32'h00);
            rreg(IDX_TMR_COUNT);
            c = rdata[15:0];
            if (k == 0) wreg(IDX_FLAGS, 32'h1f);
            wreg(IDX_CONTROL[0], {24'h0, 4'h8, MODE_CAP_RISE});
            drive[0] <= 1'b1;
            repeat (8) @(posedge clk);
            drive[0] <= 1'b0;
            wreg(IDX_CONTROL[0], 32'h0);
            rreg(IDX_VALUE[0] + IDX_HIGH_STEP);
            `CHECK(rdata[7:0], c[15:8])
            rreg(IDX_VALUE[0]);
            `CHECK(rdata[7:0], c[7:0])
        end
        repeat (20) @(posedge clk);
        rreg(IDX_FLAGS);
        `CHECK(rdata[0], 1'b1)
        wreg(IDX_FLAGS, 32'h01);
        rreg(IDX_FLAGS);
        `CHECK(rdata[0], 1'b0)
        $display("test_capture done");
    endtask
    // PWM with period 9 and duty 6 under both hardware-limit polarities.
    task automatic test_hwlimit();
        int n;
        int hi;
        int lo;
        logic [15:0] c;
        drive_en <= 5'h00;
        wreg(IDX_CONTROL[0], 32'h0);
        wreg(IDX_TMR_PERIOD, 32'h9);
        wreg(IDX_VALUE[0], 32'h6);
        wreg(IDX_VALUE[0] + IDX_HIGH_STEP, 32'h0);
        wreg(IDX_CONTROL[0], {24'h0, 4'h8, MODE_PWM});
        // Start from a hold so the stale count above the period is cleared.
        ext_reset <= 1'b1;
        wreg(IDX_TMR_CTL, {24'h0, 3'b100, TMR_HOLD_HIGH});
        repeat (8) @(posedge clk);
        ext_reset <= 1'b0;
        wait_pin(1'b0, n);
        wait_pin(1'b1, n);
        wait_pin(1'b0, hi);
        wait_pin(1'b1, lo);
        `CHECK(hi, 6)
        `CHECK(hi + lo, 10)
        ext_reset <= 1'b1;
        repeat (30) @(posedge clk);
        `CHECK(pin_out[0], 1'b1)
        rreg(IDX_TMR_COUNT);
        `CHECK(rdata[15:0], 16'h0)
        ext_reset <= 1'b0;
        wait_pin(1'b0, n);
        `CHECK(n >= 10 && n <= 14, 1'b1)
        wreg(IDX_TMR_CTL, {24'h0, 3'b100, TMR_HOLD_LOW});
        repeat (10) @(posedge clk);
        rreg(IDX_TMR_COUNT);
        `CHECK(rdata[15:0], 16'h0)
        ext_reset <= 1'b1;
        repeat (20) @(posedge clk);
        wreg(IDX_TMR_CTL, {24'h0, 3'b000, TMR_HOLD_LOW});
        rreg(IDX_TMR_COUNT);
        c = rdata[15:0];
        ext_reset <= 1'b0;
        repeat (10) @(posedge clk);
        rreg(IDX_TMR_COUNT);
        `CHECK(rdata[15:0], c)
        $display("test_hwlimit done");
    endtask
    // Open-drain PWM: the pin is only ever pulled low or released to the pull-up.
    task automatic test_drain();
        logic seen_rel;
        logic seen_drv;
        logic any_high;
        seen_rel = 1'b0;
        seen_drv = 1'b0;
        any_high = 1'b0;
        wreg(IDX_CONTROL[0], {24'h0, 4'hc, MODE_PWM});
        wreg(IDX_TMR_CTL, 32'h80);
        repeat (40) begin
            @(posedge clk);
            seen_rel |= pin_oe_n[0] & wire_lvl[0];
            seen_drv |= ~pin_oe_n[0];
            any_high |= pin_out[0];
        end
        `CHECK({seen_rel, seen_drv, any_high}, 3'b110)
        $display("test_drain done");
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Whole run is a few thousand cycles; this span is more than ten times that.
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ext_reset = 1'b0;
        drive = '0;
        drive_en = 5'h01;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_modes();
        test_capture();
        test_hwlimit();
        test_drain();
        conclude();
    end
endmodule
bind ccp_block ccp_block_checker chk (.i_sys_clk, .i_rst_n, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .o_pin_out, .o_pin_oe_n, .i_ext_reset);
`default_nettype wire
